//--- fpd_pkg.sv
// constants and types shared by the float format datapath and its short float converter
// Summary of operation
// RL1: every arithmetic, multiply or shift operation finishes in one clock cycle.
// RL2: a result written this cycle is readable by any unit next cycle.
// RL3: units share a ten-port file of sixteen primary plus sixteen alternate registers.
// RL4: denormal operands are read as zero and never raise underflow.
// RL5: denormal or underflowing results become zero and raise underflow.
// RL6: only round-to-nearest and round-toward-zero exist; no rounding toward infinity.
// RL7: precision_select clear gives 40-bit floats, 8-bit exponent, 32-bit mantissa.
// RL8: precision_select set gives 24-bit mantissa; input low eight bits forced zero.
// RL9: standard precision rounds mantissa to 23 bits and clears result low eight bits.
// RL10: short float is sign, four-bit exponent and 11-bit mantissa.
// RL11: short float sits in the low 16 bits of the 32-bit float field.
// RL12: shifter short_float_pack turns a 32-bit float into a short float.
// RL13: shifter short_float_unpack turns a short float back into a 32-bit float.
// RL14: pack and unpack each finish in one clock cycle.
// RL15: too-small packed values get exponent zero and a right-shifted mantissa with hidden one.
// RL16: unpacking a short denormal yields a properly normalised 32-bit float.
// RL17: shifter does logical, arithmetic, bit, field and exponent operations on 32 bits.
// RL18: precision_select is bit 16 of mode_control_word; one means 32-bit rounding.
// RL19: round-to-nearest breaks exact ties toward an even least significant bit.
package fpd_pkg;
   // word layout
   localparam int FPD_WORD_W = 40;
   localparam int FPD_FIX_W = 32;
   localparam int FPD_RF_AW = 4;
   localparam int FPD_RF_DEPTH = 32;
   localparam logic [39:0] FPD_WORD_RST = 40'h00_0000_0000;
   // mode_control_word fields
   localparam int MODE_TRUNC_BIT = 15;
   localparam int MODE_PREC_BIT = 16;
   // float exponent handling
   localparam logic signed [11:0] FPD_EXP_BIAS = 12'sh07F;
   localparam logic signed [11:0] FPD_EXP_ONE = 12'sh001;
   localparam logic signed [11:0] FPD_EXP_TOP = 12'sh0FF;
   localparam logic [7:0] FPD_EXP_INF = 8'hFF;
   localparam logic [32:0] FPD_ULP_EXT = 33'h0_0000_0001;
   localparam logic [32:0] FPD_ULP_STD = 33'h0_0000_0100;
   localparam logic [39:0] FPD_FONE = 40'h3F_8000_0000;
   // short float conversion
   localparam logic signed [9:0] SHORT_REBIAS = 10'sh078;
   localparam logic signed [9:0] SHORT_EXP_LIM = 10'sh010;
   localparam logic signed [9:0] SHORT_DEN_SHIFT = 10'sh00D;
   localparam logic [7:0] SHORT_DEN_REBIAS = 8'h6E;
   localparam logic [14:0] SHORT_MAX = 15'h7FFF;
   // operation codes
   typedef enum logic [3:0] {
      FPD_ALU_FADD = 4'h0, FPD_ALU_FSUB = 4'h1, FPD_ALU_IADD = 4'h2,
      FPD_ALU_IAND = 4'h3, FPD_ALU_IOR = 4'h4, FPD_ALU_IXOR = 4'h5
   } fpd_alu_op_t;
   typedef enum logic [3:0] {
      FPD_MUL_FMUL = 4'h0, FPD_MUL_IMUL = 4'h1
   } fpd_mul_op_t;
   typedef enum logic [3:0] {
      FPD_SHF_LSH = 4'h0, FPD_SHF_ASH = 4'h1, FPD_SHF_BSET = 4'h2, FPD_SHF_BCLR = 4'h3,
      FPD_SHF_FDEP = 4'h4, FPD_SHF_FEXT = 4'h5, FPD_SHF_EXP = 4'h6,
      FPD_SHF_PACK = 4'h7, FPD_SHF_UNPACK = 4'h8
   } fpd_shf_op_t;
endpackage

//--- fpd_short_cvt.sv
// short float pack and unpack conversion, purely combinational
`timescale 1ns/100ps
module fpd_short_cvt
   import fpd_pkg::*;
(
   input wire logic i_pack,
   input wire logic [31:0] i_word,
   output logic [31:0] o_word
);
   logic signed [9:0] es;
   logic [23:0] mfull;
   logic [4:0] lead;
   logic [33:0] nm;
   logic [9:0] sh;

   // one shared path so pack and unpack both settle inside one cycle
   always_comb begin
      es = $signed({2'b00, i_word[30:23]}) - SHORT_REBIAS;
      mfull = {1'b1, i_word[22:0]};
      lead = 5'h00;
      for (int i = 0; i < 11; i++) begin
         if (i_word[i]) begin
            lead = 5'(i);
         end
      end
      nm = 34'(i_word[10:0]) << (5'd23 - lead);
      sh = 10'(SHORT_DEN_SHIFT - es);
      o_word = 32'h0000_0000;
      if (i_pack) begin // RL12 RL14
         if (i_word[30:23] == 8'h00) begin
            o_word = {16'h0000, i_word[31], 15'h0000}; // RL11
         end else if (es >= SHORT_EXP_LIM) begin
            o_word = {16'h0000, i_word[31], SHORT_MAX}; // saturate, no short infinity
         end else if (es > 10'sh000) begin
            o_word = {16'h0000, i_word[31], es[3:0], i_word[22:12]}; // RL10
         end else if (sh < 10'h018) begin
            o_word = {16'h0000, i_word[31], 4'h0, 11'(mfull >> sh)}; // RL15
         end else begin
            o_word = {16'h0000, i_word[31], 15'h0000};
         end
      end else begin // RL13 RL14
         if (i_word[14:11] != 4'h0) begin
            o_word = {i_word[15], 8'(i_word[14:11]) + 8'(SHORT_REBIAS), i_word[10:0], 12'h000};
         end else if (i_word[10:0] != 11'h000) begin
            o_word = {i_word[15], 8'(lead) + SHORT_DEN_REBIAS, nm[22:0]}; // RL16
         end else begin
            o_word = {i_word[15], 31'h0000_0000};
         end
      end
   end
endmodule

//--- fpd_core.sv
// float format datapath: shared register file, alu, multiplier and shifter
`timescale 1ns/100ps
module fpd_core
   import fpd_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   input wire logic [31:0] i_mode_control_word,
   input wire logic i_alt_sel,
   input wire logic i_alu_vld,
   input wire logic [3:0] i_alu_op,
   input wire logic [3:0] i_alu_xa,
   input wire logic [3:0] i_alu_ya,
   input wire logic [3:0] i_alu_dst,
   input wire logic i_mul_vld,
   input wire logic [3:0] i_mul_op,
   input wire logic [3:0] i_mul_xa,
   input wire logic [3:0] i_mul_ya,
   input wire logic [3:0] i_mul_dst,
   input wire logic i_shf_vld,
   input wire logic [3:0] i_shf_op,
   input wire logic [3:0] i_shf_xa,
   input wire logic [3:0] i_shf_ya,
   input wire logic [3:0] i_shf_dst,
   input wire logic i_ext_we,
   input wire logic [4:0] i_ext_addr,
   input wire logic [39:0] i_ext_wdata,
   output logic [39:0] o_ext_rdata,
   output logic o_alu_unf,
   output logic o_mul_unf
);

   ////////////////////////////////////////////////////////////////////////////////
   // arithmetic helpers

   // unpack a register word into {zero, sign, exponent, mantissa with hidden one}
   function automatic logic [41:0] fpd_opnd(input logic [39:0] w, input logic std);
      logic [39:0] v;
      v = std ? {w[39:8], 8'h00} : w; // RL8
      if (v[38:31] == 8'h00) begin
         fpd_opnd = {1'b1, v[39], 8'h00, 32'h0000_0000}; // RL4
      end else begin
         fpd_opnd = {1'b0, v[39], v[38:31], 1'b1, v[30:0]}; // RL7
      end
   endfunction

   // normalise, round and range-check; m has weight one at bit 63; returns {unf, word}
   function automatic logic [40:0] fpd_round(input logic s, input logic signed [11:0] e,
         input logic [63:0] m, input logic std, input logic trunc);
      logic [63:0] mn;
      logic signed [11:0] en;
      logic [32:0] sum;
      logic g;
      logic st;
      logic lsb;
      int lz;
      lz = 64;
      for (int i = 0; i < 64; i++) begin
         if (m[i]) begin
            lz = 63 - i;
         end
      end
      mn = m << lz;
      en = e - 12'(lz);
      sum = {1'b0, (std ? {mn[63:40], 8'h00} : mn[63:32])}; // RL9
      g = std ? mn[39] : mn[31];
      st = std ? |mn[38:0] : |mn[30:0];
      lsb = std ? mn[40] : mn[32];
      // truncation simply drops bits, so the truncate path never rounds away from zero
      if (!trunc && g && (st || lsb)) begin // RL6 RL19
         sum = sum + (std ? FPD_ULP_STD : FPD_ULP_EXT);
      end
      if (sum[32]) begin
         sum = sum >> 1;
         en = en + FPD_EXP_ONE;
      end
      if (m == 64'h0000_0000_0000_0000) begin
         fpd_round = {1'b0, FPD_WORD_RST};
      end else if (en <= 12'sh000) begin
         fpd_round = {1'b1, FPD_WORD_RST}; // RL5
      end else if (en >= FPD_EXP_TOP) begin
         fpd_round = {1'b0, s, FPD_EXP_INF, 31'h0000_0000};
      end else begin
         fpd_round = {1'b0, s, en[7:0], sum[30:0]};
      end
   endfunction

   // float add; the smaller operand keeps a sticky bit so ties round correctly
   function automatic logic [40:0] fpd_fadd(input logic [39:0] x, input logic [39:0] y,
         input logic sub, input logic std, input logic trunc);
      logic [41:0] a;
      logic [41:0] b;
      logic [41:0] t;
      logic [63:0] mb;
      logic [63:0] mr;
      logic [7:0] d;
      a = fpd_opnd(x, std);
      b = fpd_opnd(y, std);
      b[40] = b[40] ^ sub;
      if (b[39:0] > a[39:0]) begin
         t = a;
         a = b;
         b = t;
      end
      d = a[39:32] - b[39:32];
      mb = {1'b0, b[31:0], 31'h0000_0000};
      if (d > 8'h3E) begin
         mb = {63'h0, |mb};
      end else begin
         mb = (mb >> d) | {63'h0, |(mb << (7'h40 - 7'(d)))};
      end
      mr = (a[40] == b[40]) ? {1'b0, a[31:0], 31'h0000_0000} + mb :
                              {1'b0, a[31:0], 31'h0000_0000} - mb;
      fpd_fadd = fpd_round(a[40], $signed({4'h0, a[39:32]}) + FPD_EXP_ONE, mr, std, trunc);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // register file read side

   logic [39:0] rf_r [FPD_RF_DEPTH];
   logic [39:0] rf_nxt [FPD_RF_DEPTH];
   logic std_prec;
   logic trunc;
   logic [4:0] alu_wa;
   logic [4:0] mul_wa;
   logic [4:0] shf_wa;
   logic [39:0] alu_x;
   logic [39:0] alu_y;
   logic [39:0] mul_x;
   logic [39:0] mul_y;
   logic [39:0] shf_x;
   logic [39:0] shf_y;

   // six read ports, three unit write ports and the external port make ten
   assign std_prec = i_mode_control_word[MODE_PREC_BIT]; // RL18
   assign trunc = i_mode_control_word[MODE_TRUNC_BIT];
   assign alu_wa = {i_alt_sel, i_alu_dst};
   assign mul_wa = {i_alt_sel, i_mul_dst};
   assign shf_wa = {i_alt_sel, i_shf_dst};
   assign alu_x = rf_r[{i_alt_sel, i_alu_xa}]; // RL3
   assign alu_y = rf_r[{i_alt_sel, i_alu_ya}];
   assign mul_x = rf_r[{i_alt_sel, i_mul_xa}];
   assign mul_y = rf_r[{i_alt_sel, i_mul_ya}];
   assign shf_x = rf_r[{i_alt_sel, i_shf_xa}];
   assign shf_y = rf_r[{i_alt_sel, i_shf_ya}];

   ////////////////////////////////////////////////////////////////////////////////
   // computation units, all combinational so each finishes in its issue cycle

   logic [40:0] alu_out;
   logic [40:0] mul_out;
   logic [39:0] shf_res;
   logic [31:0] sx;
   logic [31:0] sy;
   logic [31:0] fmask;
   logic [31:0] cvt_out;
   logic [7:0] amt;
   logic [5:0] red;
   logic [41:0] mul_xo;
   logic [41:0] mul_yo;
   // multiplier operands unpacked once so the flush test and the product share them
   assign mul_xo = fpd_opnd(mul_x, std_prec);
   assign mul_yo = fpd_opnd(mul_y, std_prec);

   // alu and multiplier; fixed-point results fill the upper 32 bits
   always_comb begin // RL1
      alu_out = {1'b0, FPD_WORD_RST};
      unique case (i_alu_op)
         FPD_ALU_FADD: alu_out = fpd_fadd(alu_x, alu_y, 1'b0, std_prec, trunc);
         FPD_ALU_FSUB: alu_out = fpd_fadd(alu_x, alu_y, 1'b1, std_prec, trunc);
         FPD_ALU_IADD: alu_out = {1'b0, alu_x[39:8] + alu_y[39:8], 8'h00};
         FPD_ALU_IAND: alu_out = {1'b0, alu_x[39:8] & alu_y[39:8], 8'h00};
         FPD_ALU_IOR: alu_out = {1'b0, alu_x[39:8] | alu_y[39:8], 8'h00};
         FPD_ALU_IXOR: alu_out = {1'b0, alu_x[39:8] ^ alu_y[39:8], 8'h00};
         default: alu_out = {1'b0, FPD_WORD_RST};
      endcase
      mul_out = {1'b0, FPD_WORD_RST};
      unique case (i_mul_op)
         FPD_MUL_FMUL: begin
            if (!mul_xo[41] && !mul_yo[41]) begin
               mul_out = fpd_round(mul_x[39] ^ mul_y[39],
                  $signed({4'h0, mul_x[38:31]}) + $signed({4'h0, mul_y[38:31]})
                  - FPD_EXP_BIAS + FPD_EXP_ONE,
                  64'(mul_xo[31:0]) * 64'(mul_yo[31:0]),
                  std_prec, trunc);
            end
         end
         FPD_MUL_IMUL: mul_out = {1'b0, 32'(mul_x[39:8] * mul_y[39:8]), 8'h00};
         default: mul_out = {1'b0, FPD_WORD_RST};
      endcase
   end

   // shifter operand fields: y gives the amount, or the field position and length
   assign sx = shf_x[39:8];
   assign sy = shf_y[39:8];
   assign amt = sy[7:0];
   assign fmask = 32'((33'h0_0000_0001 << sy[10:5]) - 33'h0_0000_0001);

   fpd_short_cvt u_cvt (
      .i_pack(i_shf_op == FPD_SHF_PACK),
      .i_word(sx),
      .o_word(cvt_out)
   );

   // shifter; a negative amount shifts right, beyond 31 positions gives all sign or zero
   always_comb begin // RL17
      red = 6'h00;
      for (int i = 30; i >= 0; i--) begin
         if (sx[i] == sx[31] && red == 6'(30 - i)) begin
            red = red + 6'h01;
         end
      end
      shf_res = FPD_WORD_RST;
      unique case (i_shf_op)
         FPD_SHF_LSH: begin
            if (amt[7]) begin
               shf_res = {(8'(-amt) > 8'h1F) ? 32'h0000_0000 : sx >> 8'(-amt), 8'h00};
            end else begin
               shf_res = {(amt > 8'h1F) ? 32'h0000_0000 : sx << amt, 8'h00};
            end
         end
         FPD_SHF_ASH: begin
            if (amt[7]) begin
               shf_res = {32'($signed(sx) >>> ((8'(-amt) > 8'h1F) ? 8'h1F : 8'(-amt))), 8'h00};
            end else begin
               shf_res = {(amt > 8'h1F) ? 32'h0000_0000 : sx << amt, 8'h00};
            end
         end
         FPD_SHF_BSET: shf_res = {sx | (32'h0000_0001 << sy[4:0]), 8'h00};
         FPD_SHF_BCLR: shf_res = {sx & ~(32'h0000_0001 << sy[4:0]), 8'h00};
         FPD_SHF_FDEP: shf_res = {(sx & fmask) << sy[4:0], 8'h00};
         FPD_SHF_FEXT: shf_res = {(sx >> sy[4:0]) & fmask, 8'h00};
         FPD_SHF_EXP: shf_res = {32'(-$signed({26'h0, red})), 8'h00};
         FPD_SHF_PACK: shf_res = {cvt_out, 8'h00}; // RL12 RL14
         FPD_SHF_UNPACK: shf_res = {cvt_out, 8'h00}; // RL13 RL14
         default: shf_res = FPD_WORD_RST;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register file write side: alu beats multiplier beats shifter beats external port

   for (genvar g = 0; g < FPD_RF_DEPTH; g++) begin : g_rf
      // writing at the edge ending the issue cycle makes the result readable next cycle
      always_comb begin // RL2
         rf_nxt[g] = rf_r[g];
         if (i_ext_we && i_ext_addr == 5'(g)) begin
            rf_nxt[g] = i_ext_wdata;
         end
         if (i_shf_vld && shf_wa == 5'(g)) begin
            rf_nxt[g] = shf_res;
         end
         if (i_mul_vld && mul_wa == 5'(g)) begin
            rf_nxt[g] = mul_out[39:0];
         end
         if (i_alu_vld && alu_wa == 5'(g)) begin
            rf_nxt[g] = alu_out[39:0];
         end
      end
      always_ff @(posedge i_ref_clk) begin
         if (!i_nrst) begin
            rf_r[g] <= FPD_WORD_RST;
         end else begin
            rf_r[g] <= rf_nxt[g];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // status pulses and external read data

   logic alu_unf_nxt;
   logic mul_unf_nxt;
   logic [39:0] ext_rd_nxt;

   // underflow pulses only for issued float operations; flushed inputs never set them
   always_comb begin // RL5
      alu_unf_nxt = i_alu_vld && alu_out[40];
      mul_unf_nxt = i_mul_vld && mul_out[40];
      ext_rd_nxt = rf_r[i_ext_addr];
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         o_alu_unf <= 1'b0;
         o_mul_unf <= 1'b0;
         o_ext_rdata <= FPD_WORD_RST;
      end else begin
         o_alu_unf <= alu_unf_nxt;
         o_mul_unf <= mul_unf_nxt;
         o_ext_rdata <= ext_rd_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);

   logic alu_fop;
   assign alu_fop = i_alu_op == FPD_ALU_FADD || i_alu_op == FPD_ALU_FSUB;

   sequence alu_wr_s;
      i_alu_vld;
   endsequence
   sequence alu_rd_back_s;
      {i_alt_sel, i_mul_xa} == $past(alu_wa);
   endsequence

   rf_forward_a: assert property ((alu_wr_s ##1 alu_rd_back_s) |-> mul_x == $past(alu_out[39:0])) // RL2
      else $error("alu result not visible next cycle");
   denorm_in_a: assert property ((i_alu_vld && i_alu_op == FPD_ALU_FADD && alu_x[38:31] == 8'h00
      && alu_y[38:31] == 8'h00) |=> !o_alu_unf) // RL4
      else $error("flushed denormal input raised underflow");
   unf_zero_a: assert property ((i_alu_vld && alu_out[40]) |=> (o_alu_unf
      && rf_r[$past(alu_wa)] == FPD_WORD_RST)) // RL5
      else $error("underflow result not flushed to zero");
   mul_unf_a: assert property ((i_mul_vld && i_mul_op == FPD_MUL_IMUL) |=> !o_mul_unf) // RL5
      else $error("fixed multiply raised underflow");
   trunc_one_a: assert property ((i_mul_op == FPD_MUL_FMUL && trunc && mul_y == FPD_FONE
      && mul_x[38:31] > 8'h01 && mul_x[38:31] < 8'hFE)
      |-> mul_out[39:0] == (std_prec ? {mul_x[39:8], 8'h00} : mul_x)) // RL6
      else $error("multiply by one altered value");
   std_low_a: assert property ((std_prec && alu_fop) |-> alu_out[7:0] == 8'h00) // RL9
      else $error("standard precision result has low bits");
   pack_low_a: assert property ((i_shf_op == FPD_SHF_PACK)
      |-> (shf_res[39:24] == 16'h0000 && shf_res[7:0] == 8'h00)) // RL11
      else $error("short float outside low 16 bits");
   pack_gradual_a: assert property ((i_shf_op == FPD_SHF_PACK && sx[30:23] != 8'h00
      && sx[30:23] <= 8'h78) |-> shf_res[22:19] == 4'h0) // RL15
      else $error("tiny packed value kept nonzero exponent");
   unpack_norm_a: assert property ((i_shf_op == FPD_SHF_UNPACK && sx[14:11] == 4'h0
      && sx[10:0] != 11'h000) |-> shf_res[38:31] != 8'h00) // RL16
      else $error("unpacked denormal not normalised");
   ext_read_a: assert property ((!i_ext_we && !i_alu_vld && !i_mul_vld && !i_shf_vld)
      ##1 (!i_ext_we && !i_alu_vld && !i_mul_vld && !i_shf_vld)
      |=> o_ext_rdata == $past(rf_r[i_ext_addr])) // RL3
      else $error("external read returned wrong word");
endmodule

//--- fpd_seq_model.sv
// sequencer and loader model that issues unit operations and moves register data
`timescale 1ns/100ps
module fpd_seq_model
   import fpd_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic [39:0] i_ext_rdata,
   output logic [31:0] o_mode,
   output logic o_alt_sel,
   output logic [2:0] o_vld,
   output logic [2:0][3:0] o_op,
   output logic [2:0][3:0] o_xa,
   output logic [2:0][3:0] o_ya,
   output logic [2:0][3:0] o_dst,
   output logic o_ext_we,
   output logic [4:0] o_ext_addr,
   output logic [39:0] o_ext_wdata
);
   ////////////////////////////////////////////////////////////
   // staged request for the next edge; mode and bank persist, strobes do not
   logic [31:0] s_mode = '0;
   logic s_alt = 1'b0;
   logic [2:0] s_vld = '0;
   logic [2:0][3:0] s_op = '0;
   logic [2:0][3:0] s_xa = '0;
   logic [2:0][3:0] s_ya = '0;
   logic [2:0][3:0] s_dst = '0;
   logic s_we = 1'b0;
   logic [4:0] s_addr = '0;
   logic [39:0] s_wd = '0;
   // all outputs idle at time zero
   initial begin
      {o_mode, o_alt_sel, o_vld, o_op, o_xa, o_ya, o_dst} = '0;
      {o_ext_we, o_ext_addr, o_ext_wdata} = '0;
   end
   ////////////////////////////////////////////////////////////
   // queue one unit operation for the next edge
   task automatic issue(input int u, input logic [3:0] op, xa, ya, dst);
      s_vld[u] = 1'b1;
      s_op[u] = op;
      s_xa[u] = xa;
      s_ya[u] = ya;
      s_dst[u] = dst;
   endtask
   // one clock: drive what is staged, then drop the strobes
   task automatic cyc();
      @(posedge i_ref_clk);
      o_mode <= s_mode;
      o_alt_sel <= s_alt;
      o_vld <= s_vld;
      o_op <= s_op;
      o_xa <= s_xa;
      o_ya <= s_ya;
      o_dst <= s_dst;
      o_ext_we <= s_we;
      o_ext_addr <= s_addr;
      o_ext_wdata <= s_wd;
      s_vld = '0;
      s_we = 1'b0;
      s_wd = ~s_wd; // idle write data keeps moving so a stale value never looks valid
   endtask
   task automatic wr(input logic [4:0] a, input logic [39:0] d);
      s_we = 1'b1;
      s_addr = a;
      s_wd = d;
      cyc();
   endtask
   // read data lands one edge after the address is taken
   task automatic rd(input logic [4:0] a, output logic [39:0] d);
      s_addr = a;
      cyc();
      cyc();
      #1 d = i_ext_rdata;
   endtask
   task automatic mode(input logic [31:0] m, input logic alt);
      s_mode = m;
      s_alt = alt;
   endtask
endmodule

//--- float_format_datapath_test.sv
// self-checking bench for the float format datapath
`timescale 1ns/100ps
module float_format_datapath_test;
   import fpd_pkg::*;
   ////////////////////////////////////////////////////////////
   // mode words: precision select is bit 16, truncate is bit 15
   localparam logic [31:0] M_NE = 32'h0000_0000;
   localparam logic [31:0] M_TZ = 32'h0000_8000;
   localparam logic [31:0] M_SN = 32'h0001_0000;
   localparam logic [31:0] M_SZ = 32'h0001_8000;
   localparam logic [39:0] F1 = 40'h3F_8000_0000;
   localparam logic [39:0] F2 = 40'h40_0000_0000;
   localparam logic [39:0] F3 = 40'h40_4000_0000;
   localparam logic [39:0] JUNK = 40'hA5_A5A5_A5A5;
   logic i_ref_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic [31:0] mode;
   logic alt;
   logic [2:0] vld;
   logic [2:0][3:0] op;
   logic [2:0][3:0] xa;
   logic [2:0][3:0] ya;
   logic [2:0][3:0] dst;
   logic we;
   logic [4:0] addr;
   logic [39:0] wdata;
   logic [39:0] rdata;
   logic alu_unf;
   logic mul_unf;
   int fail_count = 0;
   int checks = 0;
   always #2.5 i_ref_clk = ~i_ref_clk;
   fpd_seq_model seq (.i_ref_clk(i_ref_clk), .i_ext_rdata(rdata), .o_mode(mode),
      .o_alt_sel(alt), .o_vld(vld), .o_op(op), .o_xa(xa), .o_ya(ya), .o_dst(dst),
      .o_ext_we(we), .o_ext_addr(addr), .o_ext_wdata(wdata));
   fpd_core uut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_mode_control_word(mode),
      .i_alt_sel(alt), .i_alu_vld(vld[0]), .i_alu_op(op[0]), .i_alu_xa(xa[0]),
      .i_alu_ya(ya[0]), .i_alu_dst(dst[0]), .i_mul_vld(vld[1]), .i_mul_op(op[1]),
      .i_mul_xa(xa[1]), .i_mul_ya(ya[1]), .i_mul_dst(dst[1]), .i_shf_vld(vld[2]),
      .i_shf_op(op[2]), .i_shf_xa(xa[2]), .i_shf_ya(ya[2]), .i_shf_dst(dst[2]),
      .i_ext_we(we), .i_ext_addr(addr), .i_ext_wdata(wdata), .o_ext_rdata(rdata),
      .o_alu_unf(alu_unf), .o_mul_unf(mul_unf));
   ////////////////////////////////////////////////////////////
   task automatic chk_word(input logic [39:0] got, exp, input string what);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_flag(input logic [1:0] got, exp, input string what);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask
   task automatic final_report();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // x to r1, y to r2, one op into r3; flags looked at on the answer edge and again after the read-back
   task automatic run(input logic [31:0] m, input int u, input logic [3:0] o,
         input logic [39:0] x, y, e, input logic uf);
      logic [39:0] r;
      seq.mode(m, 1'b0);
      seq.wr(5'd3, JUNK);
      seq.wr(5'd1, x);
      seq.wr(5'd2, y);
      seq.issue(u, o, 4'd1, 4'd2, 4'd3);
      seq.cyc();
      seq.cyc();
      #1 chk_flag({alu_unf, mul_unf}, uf ? (u == 1 ? 2'b01 : 2'b10) : 2'b00, "unf");
      seq.rd(5'd3, r);
      chk_word(r, e, "result");
      chk_flag({alu_unf, mul_unf}, 2'b00, "unf pulse length");
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [39:0] r;
      seq.rd(5'd0, r);
      chk_word(r, 40'h00_0000_0000, "reg0 after reset");
      seq.rd(5'd31, r);
      chk_word(r, 40'h00_0000_0000, "reg31 after reset");
      chk_flag({alu_unf, mul_unf}, 2'b00, "unf after reset");
   endtask
   // add, then a multiply that uses the sum on the very next cycle, shifter alongside
   task automatic t_chain();
      logic [39:0] r;
      seq.mode(M_NE, 1'b0);
      seq.wr(5'd1, F1);
      seq.wr(5'd2, F2);
      seq.issue(0, 4'h0, 4'd1, 4'd2, 4'd4);
      seq.issue(2, 4'h0, 4'd1, 4'd0, 4'd6);
      seq.cyc();
      seq.issue(1, 4'h0, 4'd4, 4'd2, 4'd5);
      seq.cyc();
      seq.cyc();
      seq.rd(5'd4, r);
      chk_word(r, F3, "sum");
      seq.rd(5'd5, r);
      chk_word(r, 40'h40_C000_0000, "product of fresh sum");
      seq.rd(5'd6, r);
      chk_word(r, F1, "parallel shift");
   endtask
   // alternate bank, and alu beating multiplier on the same destination
   task automatic t_bank();
      logic [39:0] r;
      seq.mode(M_NE, 1'b1);
      seq.wr(5'd3, JUNK);
      seq.wr(5'd17, F1);
      seq.wr(5'd18, F2);
      seq.issue(0, 4'h0, 4'd1, 4'd2, 4'd3);
      seq.issue(1, 4'h0, 4'd1, 4'd2, 4'd3);
      seq.cyc();
      seq.mode(M_NE, 1'b0);
      seq.cyc();
      seq.rd(5'd19, r);
      chk_word(r, F3, "alternate bank result");
      seq.rd(5'd3, r);
      chk_word(r, JUNK, "primary bank untouched");
   endtask
   // ties: 1+3*2^-32 in 40 bits, (1+2^-23)+2^-24 in 32 bits
   task automatic t_round();
      run(M_NE, 0, 4'h0, 40'h3F_8000_0001, 40'h2F_8000_0000, 40'h3F_8000_0002, 0);
      run(M_TZ, 0, 4'h0, 40'h3F_8000_0001, 40'h2F_8000_0000, 40'h3F_8000_0001, 0);
      run(M_SN, 0, 4'h0, 40'h3F_8000_0100, 40'h33_8000_0000, 40'h3F_8000_0200, 0);
      run(M_SZ, 0, 4'h0, 40'h3F_8000_0100, 40'h33_8000_0000, 40'h3F_8000_0100, 0);
      run(M_SN, 0, 4'h0, 40'h3F_8000_0001, 40'h00_0000_0000, F1, 0);
      run(M_NE, 0, 4'h0, 40'h3F_8000_0001, 40'h00_0000_0000, 40'h3F_8000_0001, 0);
      run(M_TZ, 1, 4'h0, 40'h3F_8000_0001, F1, 40'h3F_8000_0001, 0);
   endtask
   task automatic t_unf();
      run(M_NE, 0, 4'h0, 40'h00_0000_1000, F1, F1, 0);
      run(M_NE, 0, 4'h0, 40'h00_0000_1000, 40'h80_0000_0F00, 40'h00_0000_0000, 0);
      run(M_NE, 1, 4'h0, 40'h00_0000_1000, F2, 40'h00_0000_0000, 0);
      run(M_NE, 1, 4'h0, 40'h0D_8000_0000, 40'h0D_8000_0000, 40'h00_0000_0000, 1);
      run(M_NE, 0, 4'h1, 40'h00_8000_0001, 40'h00_8000_0000, 40'h00_0000_0000, 1);
   endtask
   // short float sits in word bits 23:8 with exponent bias 7
   task automatic t_short();
      run(M_SN, 2, 4'h7, F1, 40'h0, 40'h00_0038_0000, 0);
      run(M_SN, 2, 4'h7, 40'hBF_C000_0000, 40'h0, 40'h00_00BC_0000, 0);
      run(M_SN, 2, 4'h7, 40'h3C_0000_0000, 40'h0, 40'h00_0004_0000, 0);
      run(M_SN, 2, 4'h7, 40'h3B_8000_0000, 40'h0, 40'h00_0002_0000, 0);
      run(M_SN, 2, 4'h8, 40'h00_0004_0000, 40'h0, 40'h3C_0000_0000, 0);
      run(M_SN, 2, 4'h8, 40'h00_003C_0000, 40'h0, 40'h3F_C000_0000, 0);
   endtask
   task automatic t_shift();
      run(M_NE, 2, 4'h0, 40'h00_0000_F000, 40'h00_0000_0400, 40'h00_000F_0000, 0);
      run(M_NE, 2, 4'h0, 40'h00_0000_F000, 40'h00_0000_FC00, 40'h00_0000_0F00, 0);
      run(M_NE, 2, 4'h1, 40'h80_0000_0000, 40'h00_0000_FC00, 40'hF8_0000_0000, 0);
      run(M_NE, 2, 4'h2, 40'h00_0000_F000, 40'h00_0000_0300, 40'h00_0000_F800, 0);
      run(M_NE, 2, 4'h3, 40'h00_0000_F000, 40'h00_0000_0700, 40'h00_0000_7000, 0);
      run(M_NE, 2, 4'h4, 40'h00_0000_0F00, 40'h00_0000_8800, 40'h00_000F_0000, 0);
      run(M_NE, 2, 4'h5, 40'h00_0000_F000, 40'h00_0000_8400, 40'h00_0000_0F00, 0);
      run(M_NE, 2, 4'h6, 40'h00_0000_F000, 40'h00_0000_0000, 40'hFF_FFFF_E900, 0);
   endtask
   // fixed ops ignore and clear the low byte
   task automatic t_fixed();
      run(M_NE, 0, 4'h2, 40'h00_0000_01FF, 40'h00_0000_0100, 40'h00_0000_0200, 0);
      run(M_NE, 0, 4'h3, 40'h00_0000_F000, 40'h00_0000_3C00, 40'h00_0000_3000, 0);
      run(M_NE, 0, 4'h4, 40'h00_0000_F000, 40'h00_0000_3C00, 40'h00_0000_FC00, 0);
      run(M_NE, 0, 4'h5, 40'h00_0000_F000, 40'h00_0000_3C00, 40'h00_0000_CC00, 0);
      run(M_NE, 1, 4'h1, 40'h00_0000_0300, 40'h00_0000_0500, 40'h00_0000_0F00, 0);
   endtask
   ////////////////////////////////////////////////////////////
   // about 250 cycles of work; the watchdog allows many times that
   initial begin
      #20000;
      fail_count++;
      final_report();
   end
   initial begin
      repeat (6) @(posedge i_ref_clk);
      i_nrst <= 1'b1;
      seq.cyc();
      t_reset();
      t_chain();
      t_bank();
      t_round();
      t_unf();
      t_short();
      t_shift();
      t_fixed();
      final_report();
   end
endmodule
